// ### design/pmic_regs_pkg.sv
// Package with offsets, field limits, reset tables and carriers of the block.
package pmic_regs_pkg;

  // Clock rate and the indicator step rate (sixteen steps per second).
  localparam int CLK_HZ          = 250_000_000;
  localparam int IND_STEPS_PER_S = 16;
  localparam int IND_TICK_CYCLES = CLK_HZ / IND_STEPS_PER_S;

  // Offsets of the status and fixed registers.
  localparam logic [7:0] OFS_IRQ_STATUS_0 = 8'h48;
  localparam logic [7:0] OFS_IRQ_STATUS_1 = 8'h49;
  localparam logic [7:0] OFS_IRQ_STATUS_2 = 8'h4a;
  localparam logic [7:0] OFS_THERM_OVR_LO = 8'h5d;

  // Implemented status bits and the bits that system reset clears.
  localparam logic [7:0] ST0_MASK      = 8'h3f;
  localparam logic [7:0] ST2_MASK      = 8'hdf;
  localparam logic [7:0] ST0_SYS_MASK  = 8'h03;
  localparam logic [7:0] ST1_SYS_MASK  = 8'h0f;
  localparam logic [7:0] ST2_SYS_MASK  = 8'h40;
  localparam logic [7:0] THERM_OVR_LO_RESET = 8'h58;

  // Field limits; codes beyond them are reserved.
  localparam logic [3:0] PRE_MAX_CODE  = 4'h8;
  localparam logic [4:0] CC_MAX_CODE   = 5'h15;
  localparam logic [3:0] TERM_MAX_CODE = 4'h8;
  localparam logic [2:0] CV_MIN_CODE   = 3'h1;
  localparam logic [2:0] CV_MAX_CODE   = 3'h5;
  localparam logic [1:0] FALL_RSVD     = 2'h3;

  // Index of each read/write register in the tables below.
  localparam int I_TS_CTRL = 0;
  localparam int I_HYS_COLD = 1;
  localparam int I_HYS_HOT = 2;
  localparam int I_CHG_COLD = 3;
  localparam int I_CHG_HOT = 4;
  localparam int I_WORK_COLD = 5;
  localparam int I_WORK_HOT = 6;
  localparam int I_ZONE_EN = 7;
  localparam int I_ZONE_RED = 8;
  localparam int I_COOL = 9;
  localparam int I_WARM = 10;
  localparam int I_OVR_HIGH = 11;
  localparam int I_PRE = 12;
  localparam int I_CC = 13;
  localparam int I_TERM = 14;
  localparam int I_CV = 15;
  localparam int I_THERMAL = 16;
  localparam int I_TIMER = 17;
  localparam int I_BATDET = 18;
  localparam int I_IND = 19;
  localparam int I_COIN = 20;
  localparam int I_CONV = 21;
  localparam int I_SPREAD = 22;
  localparam int I_EN0 = 23;
  localparam int I_EN1 = 24;
  localparam int I_EN2 = 25;
  localparam int NUM_CFG = 26;

  // Offset, writable bits, reset value and system-reset bits per register.
  localparam logic [7:0] CFG_ADDR [NUM_CFG] = '{
    8'h50, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59,
    8'h5a, 8'h5b, 8'h5c, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h67,
    8'h68, 8'h69, 8'h6a, 8'h80, 8'h81, 8'h40, 8'h41, 8'h42};
  localparam logic [7:0] CFG_MASK [NUM_CFG] = '{
    8'h1f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h01, 8'h5f,
    8'hff, 8'hff, 8'h3f, 8'h0f, 8'h1f, 8'h1f, 8'h07, 8'h03, 8'hf7,
    8'h01, 8'h37, 8'h07, 8'h6f, 8'hff, 8'h3f, 8'hff, 8'hdf};
  localparam logic [7:0] CFG_RESET [NUM_CFG] = '{
    8'h02, 8'h02, 8'h01, 8'h29, 8'h58, 8'h3e, 8'h4c, 8'h00, 8'h14,
    8'h37, 8'h1e, 8'h02, 8'h05, 8'h04, 8'h15, 8'h03, 8'h02, 8'he6,
    8'h01, 8'h01, 8'h03, 8'h00, 8'h00, 8'h3f, 8'hfc, 8'h5f};
  localparam logic [7:0] CFG_SYSMASK [NUM_CFG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h03, 8'h00,
    8'h00, 8'h30, 8'h00, 8'h6f, 8'hfc, 8'h3f, 8'hff, 8'hdf};

  // Indicator pin function and thermistor bias gating modes.
  typedef enum logic [1:0] {
    IND_TYPE_A = 2'b00, IND_TYPE_B = 2'b01, IND_REG = 2'b10, IND_RSVD = 2'b11
  } ind_func_e;
  typedef enum logic [1:0] {
    BIAS_OFF = 2'b00, BIAS_CH_EN = 2'b01, BIAS_CONV = 2'b10, BIAS_ON = 2'b11
  } bias_mode_e;

  // Levels that arrive from the analog side and must be synchronised.
  typedef struct packed {
    logic vbus_present;
    logic bat_present;
    logic key_level;
    logic bat_ot_chg;
    logic bat_ut_chg;
    logic bat_ot_work;
    logic bat_ut_work;
    logic ldo_oc;
    logic die_ot;
    logic bat_ov;
    logic zone_warm;
    logic zone_cool;
  } pin_s;

  // One-cycle events from logic on the same clock.
  typedef struct packed {
    logic key_short;
    logic key_long;
    logic gauge_wdt;
    logic gauge_level;
    logic wdt_expire;
    logic timer_expire;
    logic chg_start;
    logic chg_done;
  } event_s;

  // Charger settings handed to the analog charger.
  typedef struct packed {
    logic [3:0] precharge;
    logic [4:0] cc_limit;
    logic       term_en;
    logic [3:0] term_current;
    logic [1:0] thermal_reg;
    logic [7:0] timer_ctrl;
    logic       bat_detect_en;
    logic [2:0] coin_voltage;
  } chg_s;

  // Thermistor thresholds, hysteresis and zone boundaries.
  typedef struct packed {
    logic [7:0] hys_cold;
    logic [7:0] hys_hot;
    logic [7:0] chg_cold;
    logic [7:0] chg_hot;
    logic [7:0] work_cold;
    logic [7:0] work_hot;
    logic [7:0] cool;
    logic [7:0] warm;
  } thr_s;

endpackage

// ### design/pmic_irq_charger_regs.sv
// Status flags, thermistor and charger settings of the power-management unit.
//
// Overview of operation
// RULE1: Supply insert/remove flags set, cross-cleared, write-one-clear.
// RULE2: Battery insert/remove flags behave the same way.
// RULE3: Key flags clear by write or system reset.
// RULE4: Temperature flags auto-clear when temperature normal.
// RULE5: Charge start/done cross-clear; fault flags auto-clear.
// RULE6: Thermistor function select gates charging or not.
// RULE7: Bias current gating: off, channel, converting, on.
// RULE8: Bias magnitude code, default 50 microamps.
// RULE9: Cold and hot hysteresis registers stored.
// RULE10: Charge and work cold/hot thresholds stored.
// RULE11: Zone enable plus cool and warm boundaries.
// RULE12: Zone current halving and voltage step reduction.
// RULE13: Host thermistor value used when channel off; here only bits 13:8 come from the host, bits 7:0 are fixed.
// RULE14: Precharge current code, reserved codes refused.
// RULE15: Constant current code, reserved codes refused.
// RULE16: Termination enable and current, with defaults.
// RULE17: Charge voltage code, reserved codes refused.
// RULE18: Thermal regulation threshold, system reset default.
// RULE19: Safety timer slowing, lengths and enables.
// RULE20: Indicator pin modes with 1 Hz/4 Hz blink.
// RULE21: Coin-cell voltage and battery detect enable.
// RULE22: Converter enables, ramp, spread, forced PWM.
// RULE23: Zero writes and reserved bits change nothing.
// RULE24: Enabled status flags drive the interrupt output.
`timescale 1ns/1ps
module pmic_irq_charger_regs #(
  parameter int TICK_CYCLES = pmic_regs_pkg::IND_TICK_CYCLES
) (
  input  wire logic                 CLK,
  input  wire logic                 RESET_N,
  input  wire logic                 SYS_RESET_N,
  input  wire logic                 REG_WR,
  input  wire logic                 REG_RD,
  input  wire logic [7:0]           REG_ADDR,
  input  wire logic [7:0]           REG_WDATA,
  output logic      [7:0]           REG_RDATA,
  output logic                      REG_RVALID,
  input  wire pmic_regs_pkg::pin_s   PINS,
  input  wire pmic_regs_pkg::event_s EVENTS,
  input  wire logic                 THERM_CHANNEL_ON,
  input  wire logic                 TS_CONVERTING,
  input  wire logic [13:0]          TS_ADC,
  input  wire logic                 CHARGING,
  output logic                      IRQ,
  output logic      [13:0]          THERM_READING,
  output logic                      TS_BIAS_ON,
  output logic      [1:0]           TS_BIAS_SEL,
  output logic                      CHARGE_ALLOWED,
  output logic                      CHG_CURRENT_HALF,
  output logic      [2:0]           CHG_VOLT_CODE,
  output pmic_regs_pkg::chg_s        CHG_CFG,
  output pmic_regs_pkg::thr_s        THR_CFG,
  output logic      [7:0]           CONV_CTRL,
  output logic      [7:0]           CONV_SPREAD,
  output logic                      CHG_IND_O,
  output logic                      CHG_IND_OE
);
  import pmic_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detection of the analog levels.

  pin_s       sync1;
  pin_s       sync2;
  pin_s       prev;
  pin_s       rise;
  pin_s       fall;

  // Only the second stage and the previous copy feed any logic.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= PINS;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign rise = sync2 & ~prev;
  assign fall = ~sync2 & prev;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status registers.

  logic [7:0] st0;
  logic [7:0] st1;
  logic [7:0] st2;
  logic [7:0] w1c0;
  logic [7:0] w1c1;
  logic [7:0] w1c2;
  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] auto0;
  logic [7:0] auto1;
  logic [7:0] auto2;

  // A zero bit in the write data leaves its flag untouched. [RULE23]
  assign w1c0 = (REG_WR && REG_ADDR == OFS_IRQ_STATUS_0) ? REG_WDATA : '0;
  assign w1c1 = (REG_WR && REG_ADDR == OFS_IRQ_STATUS_1) ? REG_WDATA : '0;
  assign w1c2 = (REG_WR && REG_ADDR == OFS_IRQ_STATUS_2) ? REG_WDATA : '0;

  // Gauge events and temperature excursions; work-mode pair is bits 1:0.
  assign set0 = {2'b00, EVENTS.gauge_wdt, EVENTS.gauge_level,
                 rise.bat_ot_chg, rise.bat_ut_chg,
                 rise.bat_ot_work, rise.bat_ut_work}; // [RULE3] [RULE4]
  assign auto0 = {4'h0, ~sync2.bat_ot_chg, ~sync2.bat_ut_chg,
                  ~sync2.bat_ot_work, ~sync2.bat_ut_work}; // [RULE4]

  // Insert and remove flags clear each other. [RULE1] [RULE2]
  assign set1 = {rise.vbus_present, fall.vbus_present,
                 rise.bat_present, fall.bat_present,
                 EVENTS.key_short, EVENTS.key_long,
                 fall.key_level, rise.key_level}; // [RULE3]
  assign auto1 = {fall.vbus_present, rise.vbus_present,
                  fall.bat_present, rise.bat_present, 4'h0}; // [RULE1] [RULE2]

  // Charge start and done clear each other, faults clear on return.
  assign set2 = {EVENTS.wdt_expire, rise.ldo_oc, 1'b0, EVENTS.chg_done,
                 EVENTS.chg_start, rise.die_ot, EVENTS.timer_expire,
                 rise.bat_ov}; // [RULE5]
  assign auto2 = {1'b0, ~sync2.ldo_oc, 1'b0, EVENTS.chg_start,
                  EVENTS.chg_done, ~sync2.die_ot, 1'b0,
                  ~sync2.bat_ov}; // [RULE5]

  // A new event wins over a write or auto clear in the same cycle; events during system reset are dropped.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      st0 <= '0;
      st1 <= '0;
      st2 <= '0;
    end else if (!SYS_RESET_N) begin
      st0 <= st0 & ~ST0_SYS_MASK; // [RULE4]
      st1 <= st1 & ~ST1_SYS_MASK; // [RULE3]
      st2 <= st2 & ~ST2_SYS_MASK;
    end else begin
      st0 <= ((st0 & ~(w1c0 | auto0)) | set0) & ST0_MASK; // [RULE23]
      st1 <= (st1 & ~(w1c1 | auto1)) | set1; // [RULE1] [RULE2] [RULE3]
      st2 <= ((st2 & ~(w1c2 | auto2)) | set2) & ST2_MASK; // [RULE5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read/write configuration registers.

  logic [7:0] cfg [NUM_CFG];

  // Reserved codes are refused whole, keeping the previous setting.
  function automatic logic legal_write(input int idx, input logic [7:0] d);
    logic ok;
    ok = 1'b1;
    unique case (idx)
      I_PRE:      ok = d[3:0] <= PRE_MAX_CODE;            // [RULE14]
      I_CC:       ok = d[4:0] <= CC_MAX_CODE;             // [RULE15]
      I_TERM:     ok = d[3:0] <= TERM_MAX_CODE;           // [RULE16]
      I_CV:       ok = d[2:0] >= CV_MIN_CODE &&
                       d[2:0] <= CV_MAX_CODE;             // [RULE17]
      I_ZONE_RED: ok = d[3:2] != FALL_RSVD &&
                       d[1:0] != FALL_RSVD;               // [RULE12]
      I_IND:      ok = d[2:1] != IND_RSVD;                // [RULE20]
      default:    ok = 1'b1;
    endcase
    return ok;
  endfunction

  // One flop group per register; system reset restores only its own bits.
  for (genvar i = 0; i < NUM_CFG; i++) begin : g_cfg
    always_ff @(posedge CLK) begin
      if (!RESET_N) begin
        cfg[i] <= CFG_RESET[i];
      end else if (!SYS_RESET_N) begin
        cfg[i] <= (cfg[i] & ~CFG_SYSMASK[i]) |
                  (CFG_RESET[i] & CFG_SYSMASK[i]); // [RULE16] [RULE18]
      end else if (REG_WR && REG_ADDR == CFG_ADDR[i] &&
                   legal_write(i, REG_WDATA)) begin
        cfg[i] <= (cfg[i] & ~CFG_MASK[i]) |
                  (REG_WDATA & CFG_MASK[i]); // [RULE23]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path; unmapped offsets read as zero.

  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (REG_ADDR)
      OFS_IRQ_STATUS_0: rd_mux = st0;
      OFS_IRQ_STATUS_1: rd_mux = st1;
      OFS_IRQ_STATUS_2: rd_mux = st2;
      OFS_THERM_OVR_LO: rd_mux = THERM_OVR_LO_RESET;
      default: begin
        for (int k = 0; k < NUM_CFG; k++) begin
          if (REG_ADDR == CFG_ADDR[k]) begin
            rd_mux = cfg[k];
          end
        end
      end
    endcase
  end

  // Read data appears one cycle after the request.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      REG_RDATA  <= '0;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RDATA  <= REG_RD ? rd_mux : 8'h00;
      REG_RVALID <= REG_RD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt line from enabled flags.

  // Registered so the output comes straight from a flop.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(st0 & cfg[I_EN0]) | |(st1 & cfg[I_EN1]) |
             |(st2 & cfg[I_EN2]); // [RULE24]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thermistor input, bias current and charge gating.

  bias_mode_e bias_mode;
  logic [1:0] fall_steps;
  logic [2:0] cv_set;

  assign bias_mode = bias_mode_e'(cfg[I_TS_CTRL][3:2]);
  assign cv_set    = cfg[I_CV][2:0];

  // Reading, bias gate and charge permission follow the settings.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      THERM_READING  <= '0;
      TS_BIAS_ON     <= 1'b0;
      TS_BIAS_SEL    <= '0;
      CHARGE_ALLOWED <= 1'b0;
    end else begin
      THERM_READING <= THERM_CHANNEL_ON ? TS_ADC :
                       {cfg[I_OVR_HIGH][5:0], THERM_OVR_LO_RESET}; // [RULE13]
      unique case (bias_mode)
        BIAS_OFF:   TS_BIAS_ON <= 1'b0;                         // [RULE7]
        BIAS_CH_EN: TS_BIAS_ON <= THERM_CHANNEL_ON;
        BIAS_CONV:  TS_BIAS_ON <= THERM_CHANNEL_ON & TS_CONVERTING;
        BIAS_ON:    TS_BIAS_ON <= 1'b1;
      endcase
      TS_BIAS_SEL <= cfg[I_TS_CTRL][1:0]; // [RULE8]
      // A fixed external input never holds the charger off.
      CHARGE_ALLOWED <= cfg[I_TS_CTRL][4] |
                        ~(sync2.bat_ot_chg | sync2.bat_ut_chg); // [RULE6]
    end
  end

  // Zone reduction applies only with zone charging enabled.
  always_comb begin
    fall_steps = 2'b00;
    if (cfg[I_ZONE_EN][0] && sync2.zone_warm) begin
      fall_steps = cfg[I_ZONE_RED][3:2];
    end else if (cfg[I_ZONE_EN][0] && sync2.zone_cool) begin
      fall_steps = cfg[I_ZONE_RED][1:0];
    end
  end

  // The reduced voltage code never drops below the lowest legal code.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      CHG_CURRENT_HALF <= 1'b0;
      CHG_VOLT_CODE    <= '0;
    end else begin
      CHG_CURRENT_HALF <= cfg[I_ZONE_EN][0] &
                          ((sync2.zone_warm & cfg[I_ZONE_RED][6]) |
                           (~sync2.zone_warm & sync2.zone_cool &
                            cfg[I_ZONE_RED][4])); // [RULE11] [RULE12]
      if (cv_set >= CV_MIN_CODE + 3'(fall_steps)) begin
        CHG_VOLT_CODE <= cv_set - 3'(fall_steps); // [RULE12]
      end else begin
        CHG_VOLT_CODE <= CV_MIN_CODE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Settings forwarded to the analog side.

  // Straight register copies; the analog circuits scale the codes.
  assign CHG_CFG.precharge     = cfg[I_PRE][3:0];     // [RULE14]
  assign CHG_CFG.cc_limit      = cfg[I_CC][4:0];      // [RULE15]
  assign CHG_CFG.term_en       = cfg[I_TERM][4];      // [RULE16]
  assign CHG_CFG.term_current  = cfg[I_TERM][3:0];
  assign CHG_CFG.thermal_reg   = cfg[I_THERMAL][1:0]; // [RULE18]
  assign CHG_CFG.timer_ctrl    = cfg[I_TIMER];        // [RULE19]
  assign CHG_CFG.bat_detect_en = cfg[I_BATDET][0];    // [RULE21]
  assign CHG_CFG.coin_voltage  = cfg[I_COIN][2:0];    // [RULE21]
  assign THR_CFG = {cfg[I_HYS_COLD], cfg[I_HYS_HOT],
                    cfg[I_CHG_COLD], cfg[I_CHG_HOT],
                    cfg[I_WORK_COLD], cfg[I_WORK_HOT],
                    cfg[I_COOL], cfg[I_WARM]}; // [RULE9] [RULE10] [RULE11]
  assign CONV_CTRL   = cfg[I_CONV];   // [RULE22]
  assign CONV_SPREAD = cfg[I_SPREAD]; // [RULE22]

  ////////////////////////////////////////////////////////////////////////////
  // Charge indicator pin.

  logic [23:0] tick_cnt;
  logic        tick;
  logic [3:0]  phase;
  logic        low_1hz;
  logic        low_4hz;
  ind_func_e   ind_func;

  // Sixteen ticks per second give both blink rates at 25% duty.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      tick_cnt <= '0;
      tick     <= 1'b0;
      phase    <= '0;
    end else begin
      tick <= (tick_cnt == 24'(TICK_CYCLES - 1));
      if (tick_cnt == 24'(TICK_CYCLES - 1)) begin
        tick_cnt <= '0;
      end else begin
        tick_cnt <= tick_cnt + 24'h000001;
      end
      if (tick) begin
        phase <= phase + 4'h1;
      end
    end
  end

  assign low_1hz  = (phase[3:2] == 2'b00);
  assign low_4hz  = (phase[1:0] == 2'b00);
  assign ind_func = ind_func_e'(cfg[I_IND][2:1]);

  // Open drain: the pin only ever pulls low, so the data is a constant.
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      CHG_IND_O  <= 1'b0;
      CHG_IND_OE <= 1'b0;
    end else begin
      CHG_IND_O <= 1'b0;
      if (!cfg[I_IND][0]) begin
        CHG_IND_OE <= 1'b0; // [RULE20]
      end else begin
        unique case (ind_func)
          IND_TYPE_A: CHG_IND_OE <= CHARGING;
          IND_TYPE_B: CHG_IND_OE <= CHARGING & low_1hz;
          IND_REG: begin
            unique case (cfg[I_IND][5:4])
              2'b00: CHG_IND_OE <= 1'b0; // [RULE20]
              2'b01: CHG_IND_OE <= low_1hz;
              2'b10: CHG_IND_OE <= low_4hz;
              2'b11: CHG_IND_OE <= 1'b1;
            endcase
          end
          IND_RSVD:   CHG_IND_OE <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions and coverage.

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  AST_VBUS_INSERT: assert property ( // [RULE1]
    SYS_RESET_N && rise.vbus_present |=> st1[7] && !st1[6])
    else $error("supply insert did not set and cross-clear");
  AST_BAT_REMOVE: assert property ( // [RULE2]
    SYS_RESET_N && fall.bat_present |=> st1[4] && !st1[5])
    else $error("battery remove did not set and cross-clear");
  AST_KEY_SYSRST: assert property ( // [RULE3]
    !SYS_RESET_N |=> st1[3:0] == 4'h0 && st0[1:0] == 2'b00)
    else $error("system reset left key or work flags set");
  AST_TEMP_NORMAL: assert property ( // [RULE4]
    SYS_RESET_N && !sync2.bat_ot_chg |=> !st0[3])
    else $error("charge over-temperature flag not cleared");
  AST_DONE_CLEARS: assert property ( // [RULE5]
    SYS_RESET_N && EVENTS.chg_done && !EVENTS.chg_start
    |=> st2[4] && !st2[3])
    else $error("charge done did not clear charge start");
  AST_BIAS_OFF: assert property ( // [RULE7]
    bias_mode == BIAS_OFF ##1 bias_mode == BIAS_OFF |-> !TS_BIAS_ON)
    else $error("bias current on while gated off");
  AST_OVERRIDE: assert property ( // [RULE13]
    !THERM_CHANNEL_ON |=> THERM_READING[7:0] == THERM_OVR_LO_RESET)
    else $error("override value not used with channel off");
  AST_CV_RESERVED: assert property ( // [RULE17]
    SYS_RESET_N && REG_WR && REG_ADDR == CFG_ADDR[I_CV] &&
    REG_WDATA[2:0] == 3'b000 |=> $stable(cfg[I_CV]))
    else $error("reserved charge voltage code accepted");
  AST_ZERO_WRITE: assert property ( // [RULE23]
    SYS_RESET_N && REG_WR && REG_ADDR == OFS_IRQ_STATUS_1 &&
    REG_WDATA == 8'h00 && st1[3] |=> st1[3])
    else $error("zero write cleared a status flag");
  AST_IRQ_QUIET: assert property ( // [RULE24]
    (st0 & cfg[I_EN0]) == 8'h00 && (st1 & cfg[I_EN1]) == 8'h00 &&
    (st2 & cfg[I_EN2]) == 8'h00 |=> !IRQ)
    else $error("interrupt raised with no enabled flag");
  AST_TERM_DEFAULT: assert property ( // [RULE16]
    !SYS_RESET_N |=> cfg[I_TERM][4])
    else $error("termination enable not restored");

  COV_VBUS: cover property (rise.vbus_present ##1 st1[7]);
  COV_W1C: cover property (st1[3] && w1c1[3] ##1 !st1[3]);
  COV_BLINK: cover property ($rose(CHG_IND_OE) && ind_func == IND_REG);
  COV_IRQ: cover property ($rose(IRQ));

endmodule // pmic_irq_charger_regs

// ### verification/host_model.sv
// Host model that drives the register port of the block.
`timescale 1ns/1ps
module host_model (
  input  wire logic       CLK,
  output logic            REG_WR,
  output logic            REG_RD,
  output logic [7:0]      REG_ADDR,
  output logic [7:0]      REG_WDATA,
  input  wire logic [7:0] REG_RDATA,
  input  wire logic       REG_RVALID
);
  // Idle bus; strobes are one-cycle pulses per access.
  initial begin
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
  end
  // A write lands at the strobe edge; bus lines are scrambled after it.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    #1;
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(posedge CLK);
    #1;
    REG_WR = 1'b0;
    REG_ADDR = ~a;
    REG_WDATA = ~d;
  endtask
  // Answer comes exactly one cycle after the read strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d,
                    output logic ok);
    @(posedge CLK);
    #1;
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(posedge CLK);
    #1;
    REG_RD = 1'b0;
    REG_ADDR = ~a;
    d = REG_RDATA;
    ok = REG_RVALID;
  endtask
endmodule // host_model

// ### verification/tb.sv
// Self-checking bench for the status and charger register bank.
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import pmic_regs_pkg::*;
  logic CLK, RESET_N, SYS_RESET_N, WR, RD, RV, IRQ, TCH, OE;
  logic [7:0] ADDR, WD, RDATA, v, CONV, SPREAD;
  logic [13:0] TS_ADC, TREAD;
  logic [2:0] VC;
  logic [1:0] BSEL;
  pin_s PINS;
  event_s EVENTS;
  int n_fail, compares;
  // 250 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  pmic_irq_charger_regs #(.TICK_CYCLES(4)) pmic_irq_charger_regs_i (
    .CLK(CLK), .RESET_N(RESET_N), .SYS_RESET_N(SYS_RESET_N),
    .REG_WR(WR), .REG_RD(RD), .REG_ADDR(ADDR), .REG_WDATA(WD),
    .REG_RDATA(RDATA), .REG_RVALID(RV), .PINS(PINS), .EVENTS(EVENTS),
    .THERM_CHANNEL_ON(TCH), .TS_CONVERTING(1'b0), .TS_ADC(TS_ADC),
    .CHARGING(1'b0), .IRQ(IRQ), .THERM_READING(TREAD), .TS_BIAS_ON(),
    .TS_BIAS_SEL(BSEL), .CHARGE_ALLOWED(), .CHG_CURRENT_HALF(),
    .CHG_VOLT_CODE(VC), .CHG_CFG(), .THR_CFG(), .CONV_CTRL(CONV),
    .CONV_SPREAD(SPREAD), .CHG_IND_O(), .CHG_IND_OE(OE));
  host_model host_model_i (.CLK(CLK), .REG_WR(WR), .REG_RD(RD),
    .REG_ADDR(ADDR), .REG_WDATA(WD), .REG_RDATA(RDATA),
    .REG_RVALID(RV));
  ////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Reads one register and compares it; a missing answer ends the run.
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic ok;
    host_model_i.rd(a, v, ok);
    if (ok !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
    `CHK(v, e)
  endtask
  // Whether a write carries only legal codes; reserved ones drop it.
  function automatic bit legal(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h61, 8'h63: legal = d[3:0] <= 4'h8;
      8'h62: legal = d[4:0] <= 5'h15;
      8'h64: legal = d[2:0] >= 3'h1 && d[2:0] <= 3'h5;
      8'h59: legal = d[3:2] != 2'h3 && d[1:0] != 2'h3;
      8'h69: legal = d[2:1] != 2'h3;
      default: legal = 1'b1;
    endcase
  endfunction
  // Pulses one event bit for a single cycle.
  task automatic pulse(input event_s e);
    @(posedge CLK);
    #1;
    EVENTS = e;
    @(posedge CLK);
    #1;
    EVENTS = '0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  logic [7:0] shadow [NUM_CFG];
  logic [7:0] d;
  initial begin
    {RESET_N, SYS_RESET_N} = 2'b01;
    PINS = '0;
    EVENTS = '0;
    TS_ADC = 14'h0000;
    TCH = 1'b0;
    n_fail = 0;
    compares = 0;
    void'($urandom(47));
    repeat (8) @(posedge CLK);
    #1 RESET_N = 1'b1;
    // Reset values of every read/write register.
    for (int i = 0; i < NUM_CFG; i++) begin
      rchk(CFG_ADDR[i], CFG_RESET[i]);
      shadow[i] = CFG_RESET[i];
    end
    rchk(8'h49, 8'h00);
    `CHK(TREAD, {CFG_RESET[I_OVR_HIGH][5:0], THERM_OVR_LO_RESET})
    `CHK(BSEL, CFG_RESET[I_TS_CTRL][1:0])
    $display("test reset values done");
    // Random writes, reserved codes included, then read back.
    for (int n = 0; n < 120; n++) begin
      int i;
      i = $urandom % NUM_CFG;
      d = 8'($urandom);
      TS_ADC = 14'($urandom);
      TCH = 1'($urandom);
      host_model_i.wr(CFG_ADDR[i], d);
      if (legal(CFG_ADDR[i], d))
        shadow[i] = (d & CFG_MASK[i]) | (shadow[i] & ~CFG_MASK[i]);
      rchk(CFG_ADDR[i], shadow[i]);
      `CHK(TREAD, TCH ? TS_ADC : {shadow[I_OVR_HIGH][5:0], 8'h58})
    end
    host_model_i.wr(8'h5d, 8'h11);
    rchk(8'h5d, 8'h58);
    rchk(8'h70, 8'h00);
    `CHK(CONV, shadow[I_CONV])
    `CHK(SPREAD, shadow[I_SPREAD])
    `CHK(VC, shadow[I_CV][2:0])
    $display("test random access done");
    // Charge done then start cross-clear; write-one clears, zero does not.
    host_model_i.wr(8'h42, 8'h18);
    pulse(8'h01);
    rchk(8'h4a, 8'h10);
    `CHK(IRQ, 1'b1)
    pulse(8'h02);
    rchk(8'h4a, 8'h08);
    host_model_i.wr(8'h4a, 8'h00);
    rchk(8'h4a, 8'h08);
    host_model_i.wr(8'h4a, 8'h08);
    rchk(8'h4a, 8'h00);
    // Supply attach and removal.
    PINS.vbus_present = 1'b1;
    repeat (4) @(posedge CLK);
    rchk(8'h49, 8'h80);
    PINS.vbus_present = 1'b0;
    repeat (4) @(posedge CLK);
    rchk(8'h49, 8'h40);
    // Short press flag holds until system reset clears it.
    pulse(8'h80);
    rchk(8'h49, 8'h48);
    @(posedge CLK);
    #1 SYS_RESET_N = 1'b0;
    @(posedge CLK);
    #1 SYS_RESET_N = 1'b1;
    rchk(8'h49, 8'h40);
    rchk(8'h65, 8'h02);
    // System reset restores only its own bits of each register.
    for (int i = 0; i < NUM_CFG; i++)
      rchk(CFG_ADDR[i], (shadow[i] & ~CFG_SYSMASK[i]) |
           (CFG_RESET[i] & CFG_SYSMASK[i]));
    // Register-controlled indicator: constant low, then released.
    host_model_i.wr(8'h69, 8'h35);
    rchk(8'h69, 8'h35);
    `CHK(OE, 1'b1)
    host_model_i.wr(8'h69, 8'h05);
    rchk(8'h69, 8'h05);
    `CHK(OE, 1'b0)
    $display("test status flags done");
    report_and_stop();
  end
endmodule // tb
